// >>> lirx_output_stage.v
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`include "lirx_consts.vh"

// How it works
// - Default: data launched on recovered clock rise
// - Host invert bit moves launch to fall
// - Hardware select pin inverts recovered clock output
// - Negative line pulse gives negative output pulse
// - Positive line pulse gives positive output pulse
// - Decoder enabled strips substitution patterns
// - Hardware equalizer pin switches equalizer
// - Host mode ignores equalizer pin
// - Host mode shared pin low resets registers
// - Shared pin: reset in host, invert otherwise
// - Undriven shared pin reads high
module lirx_output_stage #(
  parameter FIFO_DEPTH = `LIRX_FIFO_DEPTH,
  parameter FIFO_AW = 4
) (
  // Clock, reset, enable
  input wire clk_in,
  input wire rstn_in,
  input wire ce_in,
  // Line side, asynchronous to clk_in
  input wire rx_line_clk_in,
  input wire rx_line_a_in,
  input wire rx_line_b_in,
  // Mode pins, asynchronous to clk_in
  input wire host_mode_in,
  input wire shared_reset_invert_in,
  input wire rx_equalizer_enable_in,
  input wire tx_negative_data_in,
  input wire hdb3_select_in,
  // Register port
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  // Terminal side
  output reg recovered_clock_out,
  output reg rx_positive_pulse_out,
  output reg rx_negative_pulse_out,
  output reg rx_equalizer_on_out
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  reg [5:0] meta_r; // First synchroniser stage of six pins
  reg [5:0] sync_r; // Second stage, the only one logic reads
  wire lclk_s; // Synchronised line clock
  wire line_a_s; // Synchronised positive line level
  wire line_b_s; // Synchronised negative line level
  wire host_s; // Synchronised host mode
  wire shared_s; // Synchronised shared reset/invert pin
  wire eqpin_s; // Synchronised equalizer pin
  reg [1:0] meta2_r; // First stage of remaining pins
  reg [1:0] sync2_r; // Second stage of remaining pins
  wire txneg_s; // Synchronised negative transmit data pin
  wire hdbpin_s; // Synchronised line code pin
  reg lclk_d_r; // Previous line clock level
  wire lclk_rise; // Line clock rising edge
  reg [`LIRX_CTRL_W-1:0] ctrl_r; // Command register
  reg ovf_r; // Sticky FIFO overflow flag
  wire host_rst; // Register reset from shared pin
  wire inv_eff; // Effective clock inversion
  wire dec_eff; // Effective decoder enable
  wire hdb_eff; // Effective line code choice
  wire eq_eff; // Effective equalizer enable
  reg [3:0] shp_r; // Positive symbol delay line, 0 newest
  reg [3:0] shn_r; // Negative symbol delay line
  reg [3:0] shp_nxt; // Next positive delay line
  reg [3:0] shn_nxt; // Next negative delay line
  reg last_pos_r; // Polarity of last accepted pulse
  reg last_pos_nxt; // Next polarity
  wire new_p; // Incoming positive symbol
  wire new_n; // Incoming negative symbol
  wire viol; // Bipolar violation at input
  wire [3:0] clr_mask; // Delay line bits wiped by substitution
  wire step; // Delay line advance
  wire f_in_ready; // FIFO can accept
  wire f_out_valid; // FIFO has a symbol
  wire [1:0] f_out_data; // Oldest symbol, {pos, neg}
  wire f_full; // FIFO full
  wire f_empty; // FIFO empty
  wire launch; // Output update moment
  reg [31:0] rd_mux; // Read data before the register

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for every line and mode pin
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      meta_r <= 6'h30; // Shared pin idles high, as its pull-up
      sync_r <= 6'h30;
      meta2_r <= 2'h0;
      sync2_r <= 2'h0;
    end
    else if (ce_in)
    begin
      meta_r <= {shared_reset_invert_in, host_mode_in, rx_equalizer_enable_in,
                 rx_line_b_in, rx_line_a_in, rx_line_clk_in};
      sync_r <= meta_r;
      meta2_r <= {hdb3_select_in, tx_negative_data_in};
      sync2_r <= meta2_r;
    end
  end

  assign lclk_s = sync_r[0];
  assign line_a_s = sync_r[1];
  assign line_b_s = sync_r[2];
  assign eqpin_s = sync_r[3];
  assign host_s = sync_r[4];
  assign shared_s = sync_r[5];
  assign txneg_s = sync2_r[0];
  assign hdbpin_s = sync2_r[1];

  ////////////////////////////////////////////////////////////////////////
  // Line clock edge detection
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      lclk_d_r <= 1'b0;
    end
    else if (ce_in)
    begin
      lclk_d_r <= lclk_s;
    end
  end

  assign lclk_rise = lclk_s & ~lclk_d_r;

  ////////////////////////////////////////////////////////////////////////
  // Mode selection from pins or command register
  assign host_rst = host_s & ~shared_s;
  // Hardware mode: shared pin selects inversion
  assign inv_eff = host_s ? ctrl_r[`LIRX_CTRL_INV] : shared_s;
  // Hardware mode: single rail with low negative input enables decoder
  assign dec_eff = host_s ? ctrl_r[`LIRX_CTRL_DEC] : ~txneg_s;
  assign hdb_eff = host_s ? ctrl_r[`LIRX_CTRL_HDB] : hdbpin_s;
  // Host mode: pin ignored, register bit used
  assign eq_eff = host_s ? ctrl_r[`LIRX_CTRL_EQ] : eqpin_s;

  ////////////////////////////////////////////////////////////////////////
  // Command register and sticky overflow flag
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ctrl_r <= `LIRX_CTRL_RST;
      ovf_r <= 1'b0;
    end
    else if (ce_in)
    begin
      if (host_rst)
      begin
        // Shared pin low in host mode: back to defaults
        ctrl_r <= `LIRX_CTRL_RST;
        ovf_r <= 1'b0;
      end
      else
      begin
        if (reg_wr_in && host_s && reg_addr_in == `LIRX_ADDR_CTRL)
        begin
          ctrl_r <= reg_wdata_in[`LIRX_CTRL_W-1:0];
        end
        // Overflow set wins over a write-one-to-clear
        if (step && !f_in_ready)
        begin
          ovf_r <= 1'b1;
        end
        else if (reg_wr_in && reg_addr_in == `LIRX_ADDR_STAT &&
                 reg_wdata_in[`LIRX_STAT_OVF])
        begin
          ovf_r <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read, data one cycle after the strobe
  always @*
  begin
    rd_mux = 32'h00000000;
    case (reg_addr_in)
      `LIRX_ADDR_CTRL:
      begin
        rd_mux[`LIRX_CTRL_W-1:0] = ctrl_r;
      end
      `LIRX_ADDR_STAT:
      begin
        rd_mux[`LIRX_STAT_HOST] = host_s;
        rd_mux[`LIRX_STAT_INV] = inv_eff;
        rd_mux[`LIRX_STAT_DEC] = dec_eff;
        rd_mux[`LIRX_STAT_HDB] = hdb_eff;
        rd_mux[`LIRX_STAT_EQ] = eq_eff;
        rd_mux[`LIRX_STAT_EMPTY] = f_empty;
        rd_mux[`LIRX_STAT_FULL] = f_full;
        rd_mux[`LIRX_STAT_OVF] = ovf_r;
        rd_mux[`LIRX_STAT_SHARED] = shared_s;
      end
      default:
      begin
        rd_mux = 32'h00000000; // Unmapped reads as zero
      end
    endcase
  end

  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      reg_rdata_out <= 32'h00000000;
    end
    else if (ce_in)
    begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line symbol intake and violation detection
  // Both rails high together is not a valid symbol
  assign new_p = line_a_s & ~line_b_s;
  assign new_n = line_b_s & ~line_a_s;
  // Violation: pulse of same polarity as the previous pulse
  assign viol = (new_p & last_pos_r) | (new_n & ~last_pos_r);
  // Advance once per line bit; a full FIFO stalls the line path
  assign step = ce_in & lclk_rise;

  // Per-stage wipe: window 000V covers four, 00V three
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_clr
      assign clr_mask[gi] = dec_eff & viol &
        ((gi < `LIRX_WIN_B3Z) | (hdb_eff & (gi < `LIRX_WIN_HDB)));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Next delay line contents with substitution removed
  always @*
  begin
    shp_nxt = {shp_r[2:0], new_p} & ~clr_mask;
    shn_nxt = {shn_r[2:0], new_n} & ~clr_mask;
    last_pos_nxt = last_pos_r;
    if (new_p)
    begin
      last_pos_nxt = 1'b1;
    end
    else if (new_n)
    begin
      last_pos_nxt = 1'b0;
    end
  end

  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      shp_r <= 4'h0;
      shn_r <= 4'h0;
      last_pos_r <= 1'b0;
    end
    else if (host_rst && ce_in)
    begin
      shp_r <= 4'h0;
      shn_r <= 4'h0;
      last_pos_r <= 1'b0;
    end
    else if (step && f_in_ready)
    begin
      shp_r <= shp_nxt;
      shn_r <= shn_nxt;
      last_pos_r <= last_pos_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Buffer between decoder and launcher
  lirx_fifo #(
    .DW(`LIRX_SYM_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .in_valid_in(step),
    .in_ready_out(f_in_ready),
    .in_data_in({shp_r[3], shn_r[3]}),
    .out_valid_out(f_out_valid),
    .out_ready_in(launch),
    .out_data_out(f_out_data),
    .full_out(f_full),
    .empty_out(f_empty)
  );

  ////////////////////////////////////////////////////////////////////////
  // Recovered clock output and data launch
  // Launch on each line rise; with inversion off this is the output's
  // rising edge, with inversion on the output's falling edge
  assign launch = ce_in & lclk_rise;

  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      recovered_clock_out <= 1'b0;
      rx_positive_pulse_out <= 1'b0;
      rx_negative_pulse_out <= 1'b0;
      rx_equalizer_on_out <= 1'b0;
    end
    else if (ce_in)
    begin
      recovered_clock_out <= lclk_s ^ inv_eff;
      rx_equalizer_on_out <= eq_eff;
      if (launch)
      begin
        // Held for one full line period until the next launch
        if (f_out_valid)
        begin
          rx_positive_pulse_out <= f_out_data[1];
          rx_negative_pulse_out <= f_out_data[0];
        end
        else
        begin
          rx_positive_pulse_out <= 1'b0;
          rx_negative_pulse_out <= 1'b0;
        end
      end
    end
  end

endmodule // lirx_output_stage

// >>> lirx_consts.vh
`ifndef LIRX_CONSTS_VH
`define LIRX_CONSTS_VH

// Register word offsets (byte addresses)
`define LIRX_ADDR_CTRL 8'h00
`define LIRX_ADDR_STAT 8'h04

// Control register field positions
`define LIRX_CTRL_INV 0
`define LIRX_CTRL_DEC 1
`define LIRX_CTRL_HDB 2
`define LIRX_CTRL_EQ 3
`define LIRX_CTRL_W 4

// Control register default value
`define LIRX_CTRL_RST 4'h2

// Status register field positions
`define LIRX_STAT_HOST 0
`define LIRX_STAT_INV 1
`define LIRX_STAT_DEC 2
`define LIRX_STAT_HDB 3
`define LIRX_STAT_EQ 4
`define LIRX_STAT_EMPTY 5
`define LIRX_STAT_FULL 6
`define LIRX_STAT_OVF 7
`define LIRX_STAT_SHARED 8
`define LIRX_STAT_W 9

// Data path sizes
`define LIRX_FIFO_DEPTH 16
`define LIRX_SYM_W 2

// Substitution window lengths in symbols
`define LIRX_WIN_HDB 4
`define LIRX_WIN_B3Z 3

`endif

// >>> lirx_fifo.v
`timescale 1ns/1ns
`include "lirx_consts.vh"

// Symbol FIFO between the decoder and the output launcher
module lirx_fifo #(
  parameter DW = `LIRX_SYM_W,
  parameter DEPTH = `LIRX_FIFO_DEPTH,
  parameter AW = 4
) (
  // Clock, reset, enable
  input wire clk_in,
  input wire rstn_in,
  input wire ce_in,
  // Fill side
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [DW-1:0] in_data_in,
  // Drain side
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [DW-1:0] out_data_out,
  // Levels
  output wire full_out,
  output wire empty_out
);

  reg [DW-1:0] mem_r [0:DEPTH-1]; // Storage
  reg [AW-1:0] wp_r; // Write pointer
  reg [AW-1:0] rp_r; // Read pointer
  reg [AW:0] cnt_r; // Occupancy
  wire push; // Accepted write
  wire pop; // Accepted read

  assign full_out = (cnt_r == DEPTH[AW:0]);
  assign empty_out = (cnt_r == {(AW+1){1'b0}});
  assign in_ready_out = ~full_out;
  assign out_valid_out = ~empty_out;
  assign out_data_out = mem_r[rp_r];
  assign push = ce_in & in_valid_in & ~full_out;
  assign pop = ce_in & out_ready_in & ~empty_out;

  ////////////////////////////////////////////////////////////////////////
  // Storage write, no reset needed
  always @(posedge clk_in)
  begin
    if (push)
    begin
      mem_r[wp_r] <= in_data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pointers and count; wrap at depth
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop)
      begin
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (push & ~pop)
      begin
        cnt_r <= cnt_r + 1'b1;
      end
      else if (pop & ~push)
      begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule // lirx_fifo

// >>> lirx_output_stage_props.sv
`timescale 1ns/1ns
// Port checker for the receive output stage
module lirx_props (
  // Clock and reset
  input wire clk_in,
  input wire rstn_in,
  // Watched inputs
  input wire rx_line_clk_in,
  input wire host_mode_in,
  input wire shared_reset_invert_in,
  input wire rx_equalizer_enable_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  // Watched outputs
  input wire [31:0] reg_rdata_out,
  input wire recovered_clock_out,
  input wire rx_positive_pulse_out,
  input wire rx_negative_pulse_out,
  input wire rx_equalizer_on_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  reg rco1_r; // Clock output one cycle back
  reg rco2_r; // Clock output two cycles back
  wire near_edge = (recovered_clock_out != rco1_r) || (rco1_r != rco2_r);
  ////////////////////////////////////////////////////////////////////////////
  // Recent history of the clock output
  always @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
      {rco1_r, rco2_r} <= 2'b00;
    else
      {rco1_r, rco2_r} <= {recovered_clock_out, rco1_r};
  ////////////////////////////////////////////////////////////////////////////
  hw_invert_a: assert property (
    (!host_mode_in && $stable(shared_reset_invert_in))[*5] |->
    recovered_clock_out == ($past(rx_line_clk_in, 3) ^ shared_reset_invert_in))
    else $error("clock output polarity wrong in hardware mode");
  host_default_a: assert property (
    (host_mode_in && !shared_reset_invert_in)[*6] |->
    recovered_clock_out == $past(rx_line_clk_in, 3) && !rx_equalizer_on_out)
    else $error("register reset did not restore defaults");
  eq_follow_a: assert property (
    (!host_mode_in && $stable(rx_equalizer_enable_in))[*5] |->
    rx_equalizer_on_out == rx_equalizer_enable_in)
    else $error("equalizer does not follow its pin");
  eq_ignore_a: assert property (
    (host_mode_in && shared_reset_invert_in && !reg_wr_in)[*6] |->
    $stable(rx_equalizer_on_out))
    else $error("equalizer moved without a write in host mode");
  rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside its slot");
  pulse_excl_a: assert property (!(rx_positive_pulse_out && rx_negative_pulse_out))
    else $error("both pulse outputs high");
  pulse_align_a: assert property (
    ($changed(rx_positive_pulse_out) || $changed(rx_negative_pulse_out)) |->
    near_edge or ##1 $changed(recovered_clock_out))
    else $error("pulse changed away from a clock edge");
  pos_hold_a: assert property ($rose(rx_positive_pulse_out) |-> rx_positive_pulse_out[*4])
    else $error("positive pulse too short");
  neg_hold_a: assert property ($rose(rx_negative_pulse_out) |=> rx_negative_pulse_out[*3])
    else $error("negative pulse too short");
  // Main scenarios reached
  cover property ($rose(rx_positive_pulse_out));
  cover property ($rose(rx_negative_pulse_out));
  cover property (host_mode_in && $fell(rx_equalizer_on_out));
endmodule // lirx_props

bind lirx_output_stage lirx_props u_props (.clk_in, .rstn_in, .rx_line_clk_in, .host_mode_in,
  .shared_reset_invert_in, .rx_equalizer_enable_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
  .recovered_clock_out, .rx_positive_pulse_out, .rx_negative_pulse_out, .rx_equalizer_on_out);

// >>> lirx_framer.sv
`timescale 1ns/1ns
// Terminal-side framer: samples recovered pulses mid-period
module lirx_framer (
  // Clock
  input wire clk_in,
  // Expected launch polarity
  input wire inv_in,
  // Recovered stream
  input wire recovered_clock_in,
  input wire pos_in,
  input wire neg_in,
  // Tallies
  output integer pos_cnt_out,
  output integer neg_cnt_out,
  output integer slot_cnt_out,
  output integer skew_cnt_out
);
  reg rco_r; // Last clock level
  reg [1:0] ev_r; // Edge seen, delayed
  reg [1:0] lv_r; // Level after edge, delayed
  reg [1:0] held_r; // Symbol seen after launch
  initial
  begin
    {rco_r, ev_r, lv_r, held_r} = 7'h00;
    pos_cnt_out = 0;
    neg_cnt_out = 0;
    slot_cnt_out = 0;
    skew_cnt_out = 0;
  end
  // Look three cycles after each clock edge
  always @(posedge clk_in)
  begin
    rco_r <= recovered_clock_in;
    ev_r <= {ev_r[0], recovered_clock_in != rco_r};
    lv_r <= {lv_r[0], recovered_clock_in};
    if (ev_r[1] && lv_r[1] == inv_in)
    begin
      // Mid-period: symbol must still be the launched one
      slot_cnt_out <= slot_cnt_out + 1;
      pos_cnt_out <= pos_cnt_out + pos_in;
      neg_cnt_out <= neg_cnt_out + neg_in;
      if ({pos_in, neg_in} !== held_r)
        skew_cnt_out <= skew_cnt_out + 1;
    end
    else if (ev_r[1])
      held_r <= {pos_in, neg_in}; // Launch edge
  end
endmodule // lirx_framer

// >>> lirx_output_stage_test.sv
`timescale 1ns/1ns
`include "lirx_consts.vh"
// Bench for the receive output stage
module lirx_output_stage_test;
  reg clk_in, rstn_in, line_clk, a_r, b_r, host_r, sh_en_r, sh_val_r;
  reg eq_r, txn_r, hdb_r, wr_r, rd_r, inv_r;
  reg [7:0] addr_r;
  reg [31:0] wdata_r, d;
  wire [31:0] rdata;
  wire rco, pos, neg, eq_on;
  wire shared = sh_en_r ? sh_val_r : 1'b1; // Pull-up when undriven
  integer bad_count, cmp_count, pc, nc, sc, kc, i;
  logic [1:0] q[$];
  logic [1:0] pat[$];
  lirx_output_stage dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1),
    .rx_line_clk_in(line_clk), .rx_line_a_in(a_r), .rx_line_b_in(b_r), .host_mode_in(host_r),
    .shared_reset_invert_in(shared), .rx_equalizer_enable_in(eq_r), .tx_negative_data_in(txn_r),
    .hdb3_select_in(hdb_r), .reg_addr_in(addr_r), .reg_wdata_in(wdata_r), .reg_wr_in(wr_r),
    .reg_rd_in(rd_r), .reg_rdata_out(rdata), .recovered_clock_out(rco),
    .rx_positive_pulse_out(pos), .rx_negative_pulse_out(neg), .rx_equalizer_on_out(eq_on));
  lirx_framer u_frm (.clk_in(clk_in), .inv_in(inv_r), .recovered_clock_in(rco), .pos_in(pos),
    .neg_in(neg), .pos_cnt_out(pc), .neg_cnt_out(nc), .slot_cnt_out(sc), .skew_cnt_out(kc));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_in = 0;
    forever #5 clk_in = ~clk_in;
  end
  // Line clock, 80 ns, own phase
  initial
  begin
    line_clk = 0;
    #3;
    forever #40 line_clk = ~line_clk;
  end
  // Line symbols change away from the sampling edge
  always @(negedge line_clk)
    if (q.size() > 0)
      {a_r, b_r} <= q.pop_front();
    else
      {a_r, b_r} <= 2'b00;
  ////////////////////////////////////////////////////////////////////////////
  task cyc(input integer n);
    repeat (n) @(posedge clk_in);
  endtask
  task check(input [31:0] got, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  task finish_test;
  begin
    $display("Compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  task wr(input [7:0] a, input [31:0] v);
  begin
    @(posedge clk_in);
    wr_r <= 1'b1;
    addr_r <= a;
    wdata_r <= v;
    @(posedge clk_in);
    wr_r <= 1'b0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    @(posedge clk_in);
    rd_r <= 1'b1;
    addr_r <= a;
    @(posedge clk_in);
    rd_r <= 1'b0;
    #1 d = rdata;
  end
  endtask
  // Decoder model: pulse count of one polarity after stripping
  function automatic integer exp_cnt(input en, input integer w, input [1:0] sel);
    logic [1:0] o[$];
    integer k, j, n;
    reg last, v;
  begin
    o = pat;
    last = 0;
    n = 0;
    for (k = 0; k < o.size(); k++)
      if (o[k] == 2'b10 || o[k] == 2'b01)
      begin
        v = en && o[k][1] == last;
        last = o[k][1];
        if (v)
          for (j = k - w + 1; j <= k; j++)
            if (j >= 0)
              o[j] = 2'b00;
      end
    for (k = 0; k < o.size(); k++)
      if (o[k] == sel)
        n++;
    exp_cnt = n;
  end
  endfunction
  // One traffic run with given pins and control word
  task run(input h, se, sv, tn, hd, input [3:0] ctrl, input iv, rnd);
    integer p0, n0, k0, s0, t, w;
    reg en;
  begin
    host_r <= h;
    sh_en_r <= se;
    sh_val_r <= sv;
    txn_r <= tn;
    hdb_r <= hd;
    inv_r <= iv;
    cyc(8);
    if (h)
      wr(`LIRX_ADDR_CTRL, {28'h0, ctrl});
    cyc(40);
    en = h ? ctrl[1] : !tn;
    w = (h ? ctrl[2] : hd) ? 4 : 3;
    pat = {};
    if (rnd)
      repeat (40) pat.push_back(2'($urandom % 3));
    else if (w == 4)
      pat = '{2'b10, 2'b00, 2'b00, 2'b00, 2'b10, 2'b01, 2'b00, 2'b00, 2'b01};
    else
      pat = '{2'b10, 2'b00, 2'b00, 2'b10, 2'b01, 2'b00, 2'b01};
    p0 = pc;
    n0 = nc;
    k0 = kc;
    q = pat;
    t = 0;
    while (q.size() > 0 && t < 1000)
    begin
      cyc(1);
      t++;
    end
    s0 = sc;
    while (sc < s0 + 12 && t < 1000)
    begin
      cyc(1);
      t++;
    end
    if (t >= 1000)
    begin
      bad_count = bad_count + 1;
      finish_test;
    end
    check(pc - p0, exp_cnt(en, w, 2'b10));
    check(nc - n0, exp_cnt(en, w, 2'b01));
    check(kc - k0, 0);
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i = $urandom(85151);
    {rstn_in, a_r, b_r, eq_r, hdb_r, wr_r, rd_r, inv_r} = 8'h00;
    {host_r, sh_en_r, sh_val_r, txn_r} = 4'hF;
    addr_r = 8'h00;
    wdata_r = 32'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    // Substitution patterns, both window lengths
    run(1, 1, 1, 1, 0, 4'h2, 0, 0);
    run(1, 1, 1, 1, 0, 4'h6, 0, 0);
    run(0, 1, 0, 0, 0, 4'h0, 0, 0);
    run(0, 1, 0, 0, 1, 4'h0, 0, 0);
    // Registers, equalizer and shared pin; host mode first
    host_r <= 1'b1;
    sh_val_r <= 1'b1;
    cyc(8);
    wr(`LIRX_ADDR_CTRL, 32'h9);
    rd(`LIRX_ADDR_CTRL);
    check(d, 32'h9);
    check({31'h0, eq_on}, 32'h1);
    eq_r <= 1'b1;
    cyc(8);
    check({31'h0, eq_on}, 32'h1);
    rd(`LIRX_ADDR_STAT);
    check({23'h0, d[8:0]}, 32'h113);
    sh_val_r <= 1'b0;
    cyc(8);
    wr(`LIRX_ADDR_CTRL, 32'hF);
    rd(`LIRX_ADDR_CTRL);
    check(d, 32'h2);
    check({31'h0, eq_on}, 32'h0);
    host_r <= 1'b0;
    sh_en_r <= 1'b0;
    cyc(8);
    check({31'h0, eq_on}, 32'h1);
    eq_r <= 1'b0;
    cyc(8);
    check({31'h0, eq_on}, 32'h0);
    wr(`LIRX_ADDR_CTRL, 32'h5);
    rd(`LIRX_ADDR_STAT);
    check({30'h0, d[8], d[0]}, 32'h2);
    host_r <= 1'b1;
    sh_en_r <= 1'b1;
    sh_val_r <= 1'b1;
    cyc(8);
    rd(`LIRX_ADDR_CTRL);
    check(d, 32'h2);
    rd(8'h08);
    check(d, 32'h0);
    // Random traffic, decoder off, each launch edge
    run(1, 1, 1, 1, 0, 4'h1, 1, 1);
    run(0, 0, 0, 1, 0, 4'h0, 1, 1);
    run(0, 1, 0, 1, 0, 4'h0, 0, 1);
    run(1, 1, 1, 1, 0, 4'h0, 0, 1);
    finish_test;
  end
endmodule // lirx_output_stage_test
